// file: verilog/rtc_divider_rate_control.sv
/*
 * rtc configuration register a: update pending status, divider chain
 * select and periodic rate select, with the update strobe and periodic
 * flag they drive.
 * assumes i_srst is the rtc well power-good reset only; no system reset
 * reaches this block. io strobes are one cycle, synchronous to i_clk.
 */
`timescale 1ns/1ps
module rtc_divider_rate_control
   import rtc_cfg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [7:0] i_io_addr,
   input wire logic [7:0] i_io_wdata,
   input wire logic i_osc_tick,
   input wire logic i_update_inhibit,
   input wire logic i_periodic_irq_enable,
   input wire logic i_flag_clear,
   output logic [7:0] o_io_rdata,
   output logic o_io_rvalid,
   output logic o_update_pending_flag,
   output logic o_update_strobe,
   output logic o_periodic_event,
   output logic o_periodic_event_flag,
   output logic o_periodic_irq
);

   typedef struct packed {
      cfg_a_t cfg;
      logic upf;
      logic [5:0] busy;
      logic strobe;
      logic pflag;
      logic irq;
      logic pevt;
      logic [7:0] rdata;
      logic rvalid;
   } ctl_state_t;

   ctl_state_t s_q;
   ctl_state_t s_d;
   cfg_access_t acc;
   div_mode_t mode;
   logic [14:0] div_count;
   logic div_wrap;
   logic tap_event;
   logic in_window;

   // index and data port sequence
   rtc_index_port u_port (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_io_wr(i_io_wr),
      .i_io_rd(i_io_rd),
      .i_io_addr(i_io_addr),
      .i_io_wdata(i_io_wdata),
      .o_access(acc)
   );

   assign mode = decode_div(s_q.cfg.dcs); // see RQ5

   // oscillator divider and periodic tap
   rtc_divider_chain u_div (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_osc_tick(i_osc_tick),
      .i_mode(mode),
      .i_rate_exp(rate_exp(s_q.cfg.prs)), // see RQ11 see RQ12 see RQ13 see RQ14 see RQ16
      .o_count(div_count),
      .o_wrap(div_wrap),
      .o_tap_event(tap_event)
   );

   // last ticks before the one-second carry, also while stopped there;
   // held up through test bypass, where carries come too often to warn ahead
   assign in_window = (mode != DIV_RESET)
      && ((div_count >= UPF_START_COUNT) || (mode == DIV_BYP5) || (mode == DIV_BYP10)
      || (mode == DIV_BYP15));

   // register access, update pending, periodic flag
   always_comb begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      if (acc.wr) begin
         s_d.cfg.dcs = acc.wdata[DCS_MSB:DCS_LSB]; // see RQ4
         s_d.cfg.prs = acc.wdata[PRS_MSB:PRS_LSB]; // see RQ7
      end
      if (acc.rd) begin
         s_d.rdata = {s_q.upf, s_q.cfg.dcs, s_q.cfg.prs};
         s_d.rvalid = 1'b1;
      end
      if (div_wrap) begin
         s_d.busy = UPDATE_BUSY_LOAD;
      end else if (s_q.busy != 6'h00) begin
         s_d.busy = s_q.busy - 6'h01;
      end
      s_d.upf = in_window || div_wrap || (s_q.busy > 6'h01); // see RQ1 see RQ2
      s_d.strobe = div_wrap && !i_update_inhibit; // see RQ3
      s_d.pevt = tap_event; // see RQ9
      s_d.pflag = tap_event || (s_q.pflag && !i_flag_clear); // see RQ8
      s_d.irq = s_d.pflag && i_periodic_irq_enable; // see RQ18
   end

   // state register; only the rtc well power-good clears it
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_q <= '0;
         s_q.cfg.dcs <= DCS_POWERUP; // see RQ15
         s_q.cfg.prs <= PRS_POWERUP;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_io_rdata = s_q.rdata;
   assign o_io_rvalid = s_q.rvalid;
   assign o_update_pending_flag = s_q.upf;
   assign o_update_strobe = s_q.strobe;
   assign o_periodic_event = s_q.pevt;
   assign o_periodic_event_flag = s_q.pflag;
   assign o_periodic_irq = s_q.irq;

   // helper: oscillator ticks since the flag rose
   logic [15:0] lead_ticks_q;
   always_ff @(posedge i_clk) begin
      if (i_srst || !s_q.upf) begin
         lead_ticks_q <= '0;
      end else if (i_osc_tick && (lead_ticks_q != 16'hffff)) begin
         lead_ticks_q <= lead_ticks_q + 16'h0001;
      end
   end

   // helper: ticks between periodic events under a steady setting
   logic [15:0] gap_q;
   logic gap_ok_q;
   cfg_a_t gap_cfg_q;
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         gap_q <= '0;
         gap_ok_q <= 1'b0;
         gap_cfg_q <= '0;
      end else if (tap_event) begin
         gap_q <= {15'h0000, i_osc_tick}; // a tick on this edge opens the next gap
         gap_ok_q <= (mode == DIV_RUN);
         gap_cfg_q <= s_q.cfg;
      end else begin
         if (i_osc_tick && (gap_q != 16'hffff)) begin
            gap_q <= gap_q + 16'h0001;
         end
         if ((s_q.cfg != gap_cfg_q) || (mode != DIV_RUN)) begin
            gap_ok_q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   sequence s_cfg_write;
      acc.wr;
   endsequence

   sequence s_update_carry;
      div_wrap && !i_update_inhibit;
   endsequence

   property p_upf_at_update;
      s_update_carry |=> o_update_pending_flag && o_update_strobe;
   endproperty
   a_upf_at_update: assert property (p_upf_at_update) // see RQ1
      else $error("update strobe without pending flag");

   property p_upf_lead;
      (o_update_strobe && (mode == DIV_RUN) && $past(mode == DIV_RUN, 2))
         |-> (lead_ticks_q >= 16'(UPF_LEAD_TICKS));
   endproperty
   a_upf_lead: assert property (p_upf_lead) // see RQ2
      else $error("pending flag rose too late before update");

   property p_stable_when_clear;
      o_update_strobe |-> $past(o_update_pending_flag);
   endproperty
   a_stable_when_clear: assert property (p_stable_when_clear) // see RQ3
      else $error("update began while flag read zero");

   property p_field_write;
      s_cfg_write |=> (s_q.cfg.dcs == $past(acc.wdata[DCS_MSB:DCS_LSB]))
         && (s_q.cfg.prs == $past(acc.wdata[PRS_MSB:PRS_LSB]));
   endproperty
   a_field_write: assert property (p_field_write) // see RQ4
      else $error("divider select not stored");

   property p_div_reset;
      (mode == DIV_RESET) [*2] |-> (div_count == 15'h0000) && !tap_event;
   endproperty
   a_div_reset: assert property (p_div_reset) // see RQ5
      else $error("divider not held in reset");

   property p_bypass15;
      ((mode == DIV_BYP15) && i_osc_tick) |=> div_wrap;
   endproperty
   a_bypass15: assert property (p_bypass15) // see RQ6
      else $error("bypass of all stages did not carry");

   property p_rate_off;
      tap_event |-> ($past(s_q.cfg.prs) != PRS_OFF);
   endproperty
   a_rate_off: assert property (p_rate_off) // see RQ9
      else $error("periodic event with rate select zero");

   property p_flag_set;
      tap_event |=> o_periodic_event_flag && o_periodic_event;
   endproperty
   a_flag_set: assert property (p_flag_set) // see RQ8
      else $error("periodic flag not set by tap");

   property p_irq_gate;
      o_periodic_irq |-> $past(i_periodic_irq_enable) && o_periodic_event_flag;
   endproperty
   a_irq_gate: assert property (p_irq_gate) // see RQ18
      else $error("periodic interrupt without enable");

   property p_rate_period;
      (tap_event && gap_ok_q && (s_q.cfg == gap_cfg_q))
         |-> (gap_q == (16'h0001 << rate_exp(s_q.cfg.prs)));
   endproperty
   a_rate_period: assert property (p_rate_period) // see RQ11 see RQ12 see RQ13 see RQ14 see RQ16
      else $error("periodic event spacing wrong");

   // register port, flag and divider step checks
   sequence s_flag_hold;
      o_update_pending_flag [*8];
   endsequence

   sequence s_inhibited_carry;
      div_wrap && i_update_inhibit;
   endsequence

   sequence s_reset_held;
      (mode == DIV_RESET) [*2];
   endsequence

   property p_read_answer;
      acc.rd |=> o_io_rvalid
         && (o_io_rdata == {$past(s_q.upf), $past(s_q.cfg.dcs), $past(s_q.cfg.prs)});
   endproperty
   a_read_answer: assert property (p_read_answer) // see RQ1
      else $error("read data not built from the register fields");

   property p_rvalid_cause;
      o_io_rvalid |-> $past(acc.rd);
   endproperty
   a_rvalid_cause: assert property (p_rvalid_cause) // see RQ17
      else $error("read answer without a data port read");

   property p_cfg_hold;
      !acc.wr |=> (s_q.cfg == $past(s_q.cfg));
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) // see RQ15
      else $error("configuration changed without a write");

   property p_flag_clear;
      (i_flag_clear && !tap_event) |=> !o_periodic_event_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) // see RQ8
      else $error("periodic flag not cleared");

   property p_flag_hold;
      (o_periodic_event_flag && !i_flag_clear) |=> o_periodic_event_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) // see RQ8
      else $error("periodic flag dropped without clear");

   property p_irq_follow;
      o_periodic_irq == (o_periodic_event_flag && $past(i_periodic_irq_enable));
   endproperty
   a_irq_follow: assert property (p_irq_follow) // see RQ18
      else $error("periodic interrupt does not follow flag and enable");

   property p_busy_hold;
      o_update_strobe |-> s_flag_hold;
   endproperty
   a_busy_hold: assert property (p_busy_hold) // see RQ1
      else $error("pending flag fell during update");

   property p_inhibit;
      s_inhibited_carry |=> !o_update_strobe && o_update_pending_flag;
   endproperty
   a_inhibit: assert property (p_inhibit) // see RQ3
      else $error("update strobe while inhibited");

   property p_reset_quiet;
      s_reset_held |-> !div_wrap ##1 !o_update_strobe;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) // see RQ5
      else $error("update while divider held in reset");

   property p_quiet_no_update;
      (!o_update_pending_flag && (mode == DIV_RUN)) |-> !div_wrap;
   endproperty
   a_quiet_no_update: assert property (p_quiet_no_update) // see RQ2
      else $error("carry while pending flag read zero");

   property p_run_step;
      ((mode == DIV_RUN) && i_osc_tick) |=> (div_count == 15'($past(div_count) + 15'h0001));
   endproperty
   a_run_step: assert property (p_run_step) // see RQ5
      else $error("divider did not step by one in normal run");

   property p_byp5_step;
      ((mode == DIV_BYP5) && i_osc_tick)
         |=> (div_count == 15'($past(div_count) + 15'(16'h0001 << BYPASS5_SHIFT)));
   endproperty
   a_byp5_step: assert property (p_byp5_step) // see RQ6
      else $error("divider did not skip five stages");

endmodule : rtc_divider_rate_control

// file: verilog/rtc_cfg_pkg.sv
/*
 * constants, types and helper functions for the rtc configuration register
 * block: io port decode, field layout, divider modes and timing figures.
 * assumes a 40 MHz core clock and a 32.768 kHz oscillator tick.
 */
// Notes on behaviour
// RQ1 - update pending flag high near or during update
// RQ2 - flag low means no update for 244 us
// RQ3 - time bytes stable whenever flag reads zero
// RQ4 - divider select field sits in bits 6:4
// RQ5 - select 010 runs, 11x holds divider reset
// RQ6 - test selects bypass 15, 10, 5 stages
// RQ7 - rate select bits 3:0 pick divider tap
// RQ8 - each tap period sets flag, enable gates interrupt
// RQ9 - rate select 0000 gives no periodic events
// RQ10 - software sets rate zero when unused
// RQ11 - rate 0001 3.90625 ms, 0010 7.8125 ms
// RQ12 - rates 0101, 0110, 0111 give 488us to 1.95ms
// RQ13 - rates 1000, 1001, 1010 give 3.9 to 15.6ms
// RQ14 - rate 1111 gives 500 ms period
// RQ15 - no system reset touches this register
// RQ16 - remaining rates follow the doubling progression
// RQ17 - software uses index port then data port
// RQ18 - periodic enable gates periodic interrupt output
package rtc_cfg_pkg;

   // indexed io ports, standard bank and its alias
   localparam logic [7:0] IO_INDEX_ADDR = 8'h70;
   localparam logic [7:0] IO_INDEX_ALIAS = 8'h74;
   localparam logic [7:0] IO_DATA_ADDR = 8'h71;
   localparam logic [7:0] IO_DATA_ALIAS = 8'h75;
   localparam logic [6:0] CFG_A_INDEX = 7'h0a;

   // field layout of rtc_config_a
   localparam int UPF_BIT = 7;
   localparam int DCS_MSB = 6;
   localparam int DCS_LSB = 4;
   localparam int PRS_MSB = 3;
   localparam int PRS_LSB = 0;

   // divider select encodings
   localparam logic [2:0] DCS_NORMAL = 3'h2;
   localparam logic [2:0] DCS_BYPASS15 = 3'h5;
   localparam logic [2:0] DCS_BYPASS10 = 3'h4;
   localparam logic [2:0] DCS_BYPASS5 = 3'h3;
   localparam logic [1:0] DCS_RESET_TOP = 2'h3;
   localparam logic [3:0] PRS_OFF = 4'h0;

   // value taken at battery power-good only
   localparam logic [2:0] DCS_POWERUP = 3'h0;
   localparam logic [3:0] PRS_POWERUP = 4'h0;

   // divider and timing figures
   localparam int DIV_STAGES = 15;
   localparam logic [3:0] BYPASS5_SHIFT = 4'h5;
   localparam logic [3:0] BYPASS10_SHIFT = 4'ha;
   localparam logic [3:0] BYPASS15_SHIFT = 4'hf;
   localparam longint OSC_HZ = 32768;
   localparam longint CLK_HZ = 40_000_000;
   localparam longint NS_PER_S = 1_000_000_000;
   localparam longint UPF_LEAD_NS = 244_000;
   localparam int UPF_LEAD_TICKS = int'((UPF_LEAD_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S);
   localparam logic [14:0] UPF_START_COUNT = 15'(32768 - UPF_LEAD_TICKS);
   localparam longint UPDATE_BUSY_NS = 1_000;
   localparam int UPDATE_BUSY_CYCLES = int'((UPDATE_BUSY_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
   localparam logic [5:0] UPDATE_BUSY_LOAD = 6'(UPDATE_BUSY_CYCLES);

   typedef enum {DIV_STOP, DIV_RUN, DIV_RESET, DIV_BYP5, DIV_BYP10, DIV_BYP15} div_mode_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } cfg_access_t;

   typedef struct packed {
      logic [2:0] dcs;
      logic [3:0] prs;
   } cfg_a_t;

   // divider select to mode; 000 and 001 stop the chain
   function automatic div_mode_t decode_div(input logic [2:0] sel);
      div_mode_t m;
      m = DIV_STOP;
      if (sel[2:1] == DCS_RESET_TOP) begin
         m = DIV_RESET;
      end else if (sel == DCS_NORMAL) begin
         m = DIV_RUN;
      end else if (sel == DCS_BYPASS15) begin
         m = DIV_BYP15;
      end else if (sel == DCS_BYPASS10) begin
         m = DIV_BYP10;
      end else if (sel == DCS_BYPASS5) begin
         m = DIV_BYP5;
      end
      return m;
   endfunction : decode_div

   // log2 of the tap period in oscillator ticks, zero when off
   function automatic logic [3:0] rate_exp(input logic [3:0] rs);
      logic [3:0] e;
      e = 4'h0;
      if (rs == 4'h1) begin
         e = 4'h7;
      end else if (rs == 4'h2) begin
         e = 4'h8;
      end else if (rs != PRS_OFF) begin
         e = rs - 4'h1;
      end
      return e;
   endfunction : rate_exp

endpackage : rtc_cfg_pkg

// file: verilog/rtc_index_port.sv
/*
 * index and data port decode for the standard rtc bank: keeps the index
 * and turns data port cycles at index 0ah into access strobes.
 * assumes one-cycle io strobes synchronous to i_clk.
 */
`timescale 1ns/1ps
module rtc_index_port
   import rtc_cfg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [7:0] i_io_addr,
   input wire logic [7:0] i_io_wdata,
   output cfg_access_t o_access
);

   typedef struct packed {
      logic [6:0] index;
      cfg_access_t acc;
   } port_state_t;

   port_state_t s_q;
   port_state_t s_d;
   logic is_index;
   logic is_data;

   // alias decode of the two standard ports
   assign is_index = (i_io_addr == IO_INDEX_ADDR) || (i_io_addr == IO_INDEX_ALIAS);
   assign is_data = (i_io_addr == IO_DATA_ADDR) || (i_io_addr == IO_DATA_ALIAS);

   // index then data access sequence
   always_comb begin
      s_d = s_q;
      s_d.acc.wr = 1'b0;
      s_d.acc.rd = 1'b0;
      s_d.acc.wdata = i_io_wdata;
      if (i_io_wr && is_index) begin
         s_d.index = i_io_wdata[6:0]; // bit 7 belongs to nmi gating, see RQ17
      end
      if (is_data && (s_q.index == CFG_A_INDEX)) begin
         s_d.acc.wr = i_io_wr; // see RQ17
         s_d.acc.rd = i_io_rd;
      end
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_access = s_q.acc;

endmodule : rtc_index_port

// file: verilog/rtc_divider_chain.sv
/*
 * 15-stage oscillator divider with test bypass, reset hold and a
 * selectable periodic tap.
 * assumes i_osc_tick is a one-cycle pulse at the oscillator rate.
 */
`timescale 1ns/1ps
module rtc_divider_chain
   import rtc_cfg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_osc_tick,
   input div_mode_t i_mode,
   input wire logic [3:0] i_rate_exp,
   output logic [14:0] o_count,
   output logic o_wrap,
   output logic o_tap_event
);

   typedef struct packed {
      logic [14:0] cnt;
      logic wrap;
      logic tap;
   } div_state_t;

   div_state_t s_q;
   div_state_t s_d;
   logic [3:0] shift;
   logic [15:0] sum;
   logic [14:0] mask;
   logic [14:0] low_mask;
   logic running;

   // step size per mode, bypass skips the low stages
   always_comb begin
      shift = 4'h0;
      unique case (i_mode)
         DIV_BYP5: shift = BYPASS5_SHIFT; // see RQ6
         DIV_BYP10: shift = BYPASS10_SHIFT;
         DIV_BYP15: shift = BYPASS15_SHIFT;
         DIV_STOP, DIV_RUN, DIV_RESET: shift = 4'h0;
      endcase
   end

   assign running = (i_mode != DIV_STOP) && (i_mode != DIV_RESET);
   assign sum = {1'b0, s_q.cnt} + (16'h0001 << shift);
   // bypassed low stages stand still, so only the stages that count form the tap
   assign low_mask = 15'((16'h0001 << shift) - 16'h0001); // see RQ6
   assign mask = 15'((16'h0001 << i_rate_exp) - 16'h0001) & ~low_mask;

   // count, carry out of the last stage, tap match
   always_comb begin
      s_d = s_q;
      s_d.wrap = 1'b0;
      s_d.tap = 1'b0;
      if (i_mode == DIV_RESET) begin
         s_d.cnt = '0; // see RQ5
      end else if (running && i_osc_tick) begin
         s_d.cnt = sum[14:0];
         s_d.wrap = sum[15];
         s_d.tap = (i_rate_exp != 4'h0) && ((sum[14:0] & mask) == 15'h0000); // see RQ7
      end
   end

   // state register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_count = s_q.cnt;
   assign o_wrap = s_q.wrap;
   assign o_tap_event = s_q.tap;

endmodule : rtc_divider_chain

// file: bench/tb_top.sv
/*
 * self-checking bench for the rtc configuration register block: register
 * readback, refused index, periodic tap periods in run and bypass modes,
 * quiet modes, periodic flag and irq, update pending lead before update.
 * assumes a 40 MHz clock, oscillator ticks made here every second cycle.
 */
`timescale 1ns/1ps
module tb_top;
   import rtc_cfg_pkg::*;
   logic i_clk = 0, i_srst = 1, i_io_wr = 0, i_io_rd = 0, i_osc_tick = 0;
   logic [7:0] i_io_addr = 8'h00, i_io_wdata = 8'h00;
   logic i_update_inhibit = 0, i_periodic_irq_enable = 0, i_flag_clear = 0;
   logic [7:0] o_io_rdata;
   logic o_io_rvalid, o_update_pending_flag, o_update_strobe;
   logic o_periodic_event, o_periodic_event_flag, o_periodic_irq;
   int compares = 0, miscompares = 0;
   int ticks = 0, ev_n = 0, ev_prev = 0, ev_last = 0, upf_rise = 0, strobes = 0;
   int all_strobes = 0;
   logic tick_en = 0, chk_upd = 0, upf_q = 0, en_q = 0;
   // 244 us at 32.768 kHz, rounded up to whole ticks
   localparam int LEAD_TICKS = 8;

   rtc_divider_rate_control u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_io_wr(i_io_wr),
      .i_io_rd(i_io_rd), .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata),
      .i_osc_tick(i_osc_tick), .i_update_inhibit(i_update_inhibit),
      .i_periodic_irq_enable(i_periodic_irq_enable), .i_flag_clear(i_flag_clear),
      .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid),
      .o_update_pending_flag(o_update_pending_flag), .o_update_strobe(o_update_strobe),
      .o_periodic_event(o_periodic_event), .o_periodic_event_flag(o_periodic_event_flag),
      .o_periodic_irq(o_periodic_irq));

   // 25 ns clock
   initial begin
      forever #12.5 i_clk = ~i_clk;
   end

   // one oscillator tick every second cycle while enabled
   always @(posedge i_clk) begin
      #1 i_osc_tick = tick_en & ~i_osc_tick;
   end

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   // tap period in ticks: 3.90625 ms is 128 ticks, codes 4 to 15 each double the one before
   function automatic int period(input logic [3:0] rs, input int shift);
      int e;
      e = (rs == 4'h1) ? 7 : (rs == 4'h2) ? 8 : int'(rs) - 1;
      return (e >= shift) ? (1 << (e - shift)) : 1;
   endfunction : period

   // event timing, flag and irq, update lead monitor
   always @(posedge i_clk) begin
      if (i_osc_tick) ticks++;
      if (o_periodic_event === 1'b1) begin
         ev_prev = ev_last;
         ev_last = ticks;
         ev_n++;
         check("periodic_flag", o_periodic_event_flag, 1'b1);
         check("periodic_irq", o_periodic_irq, en_q);
      end
      if (o_update_pending_flag === 1'b1 && !upf_q) upf_rise = ticks;
      upf_q = (o_update_pending_flag === 1'b1);
      if (o_update_strobe === 1'b1) all_strobes++;
      // enable as the design sampled it on this edge
      en_q = i_periodic_irq_enable;
      if (o_update_strobe === 1'b1 && chk_upd) begin
         strobes++;
         check("upf_at_update", o_update_pending_flag, 1'b1);
         check("upf_lead", 32'(ticks - upf_rise >= LEAD_TICKS), 1);
      end
   end

   // one-cycle io strobes
   task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1 i_io_wr = 1;
      i_io_addr = a;
      i_io_wdata = d;
      @(posedge i_clk);
      #1 i_io_wr = 0;
   endtask : io_wr

   task automatic io_rd(input logic [7:0] a, output logic seen, output logic [7:0] d);
      @(posedge i_clk);
      #1 i_io_rd = 1;
      i_io_addr = a;
      @(posedge i_clk);
      #1 i_io_rd = 0;
      seen = 0;
      d = 8'h00;
      repeat (4) begin
         @(posedge i_clk);
         #1 if (o_io_rvalid === 1'b1 && !seen) begin
            seen = 1;
            d = o_io_rdata;
         end
      end
   endtask : io_rd

   task automatic reg_wr(input logic [7:0] d);
      io_wr(8'h70, 8'h0a);
      io_wr(8'h71, d);
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] exp);
      logic s;
      logic [7:0] d;
      io_wr(8'h70, 8'h0a);
      io_rd(8'h71, s, d);
      check("rvalid", s, 1'b1);
      check("rdata", d, exp);
   endtask : reg_rd

   // period between two events after a rate change
   task automatic measure(input logic [7:0] val, input int shift);
      int n;
      i_periodic_irq_enable = 1'($urandom);
      reg_wr(val);
      repeat (4) @(posedge i_clk);
      #1 ev_n = 0;
      n = 0;
      while (ev_n < 2 && n < 40000) begin
         @(posedge i_clk);
         #1 n++;
      end
      check("period", ev_last - ev_prev, period(val[3:0], shift));
   endtask : measure

   // no periodic events for 200 ticks
   task automatic quiet(input logic [7:0] val);
      reg_wr(val);
      repeat (4) @(posedge i_clk);
      #1 ev_n = 0;
      repeat (400) @(posedge i_clk);
      #1 check("quiet", ev_n, 0);
   endtask : quiet

   // watchdog
   initial begin
      repeat (100000) @(posedge i_clk);
      miscompares++;
      conclude();
   end

   initial begin
      logic [7:0] v;
      logic s;
      logic [7:0] d;
      int n;
      void'($urandom(71302));
      repeat (8) @(posedge i_clk);
      #1 i_srst = 0;
      reg_rd(8'h00);
      // every divider select with random rate, bit 7 read only
      for (int k = 0; k < 8; k++) begin
         v = 8'($urandom);
         v[6:4] = 3'(k);
         reg_wr(v);
         reg_rd({1'(k inside {[3:5]}), v[6:0]});
      end
      // other index through the alias ports is refused
      io_wr(8'h74, 8'h0b);
      io_wr(8'h75, 8'h5a);
      io_rd(8'h75, s, d);
      check("refused_rvalid", s, 1'b0);
      reg_rd({1'b0, v[6:0]});
      $display("test readback done");
      tick_en = 1;
      reg_wr(8'h60);
      repeat (20) @(posedge i_clk);
      #1 chk_upd = 1;
      for (int r = 1; r < 13; r++) begin
         measure(8'h20 | 8'(r), 0);
      end
      $display("test rates done");
      i_flag_clear = 1;
      @(posedge i_clk);
      #1 i_flag_clear = 0;
      repeat (3) @(posedge i_clk);
      #1 check("flag_clear", o_periodic_event_flag, 1'b0);
      check("irq_clear", o_periodic_irq, 1'b0);
      quiet(8'h20);
      n = 0;
      while (strobes < 1 && n < 70000) begin
         @(posedge i_clk);
         #1 n++;
      end
      check("update_count", strobes, 1);
      chk_upd = 0;
      $display("test update done");
      measure(8'h3d, 5);
      measure(8'h4e, 10);
      measure(8'h4f, 10);
      measure(8'h5f, 15);
      // full bypass carries every tick; inhibit stops the strobe only
      i_update_inhibit = 1;
      repeat (4) @(posedge i_clk);
      #1 n = all_strobes;
      repeat (20) @(posedge i_clk);
      #1 check("inhibited_strobes", all_strobes - n, 0);
      check("inhibit_flag", o_update_pending_flag, 1'b1);
      i_update_inhibit = 0;
      repeat (24) @(posedge i_clk);
      #1 check("resumed_strobes", 32'(all_strobes - n > 0), 1);
      quiet(8'h63);
      quiet(8'h73);
      $display("test bypass and hold done");
      conclude();
   end
endmodule : tb_top
